/* design/sso_top.v */
// Purpose: Digital status outputs of a servo drive, each picked by a selection code.
// Assumes: Condition inputs are synchronous to SYS_CLK; the overload tick counts time units.
// Notes: Registers reached over APB; one level interrupt out of sticky event bits.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "sso_consts.vh"
module sso_top (
    input wire SYS_CLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire OVERLOAD,
    input wire OL_TICK,
    input wire REV_LIMIT_ERR,
    input wire FWD_LIMIT_ERR,
    input wire ESTOP,
    input wire COMM_ERR,
    input wire UNDERVOLT,
    input wire OTHER_FAULT,
    input wire REV_SOFT_LIMIT,
    input wire FWD_SOFT_LIMIT,
    input wire [2:0] CTRL_MODE,
    input wire [15:0] SPEED_ERR,
    output reg [5:0] DO_OUT,
    output reg OVERLOAD_ALARM_DISPLAY,
    output reg IRQ
);

    reg [7:0] sel_r [0:5];
    reg [31:0] perm_r;
    reg [7:0] pct_r;
    reg [15:0] win_r;
    reg [15:0] sword_r;
    reg [31:0] ol_time_r;
    reg [31:0] ol_time_nxt;
    reg [31:0] warn_thr_r;
    reg alarm_r;
    reg [5:0] ev_r;
    reg [5:0] ev_nxt;
    reg [5:0] mask_r;
    reg [5:0] prev_r;
    reg [5:0] do_nxt;
    reg [31:0] rdata_nxt;
    wire [5:0] src;
    wire [39:0] prod;
    wire warn_src;
    wire fault_src;
    wire spok_src;
    wire olw_src;
    wire wr_en;
    wire rd_en;
    wire clr_req;
    wire [39:0] thr_full;
    integer i;
    // The reset loop has its own index, so each loop variable belongs to one process.
    integer j;

    // The selection decode is used for every output pin, so it lives in one function.
    function sel_decode;
        input [7:0] code;
        input overload_warning_out;
        input fault;
        input warn;
        input rlim;
        input flim;
        input spok;
        input [15:0] word;
        begin
            if (code >= `SSO_CODE_SDO0 && code <= `SSO_CODE_SDOF)
            begin
                sel_decode = word[code[3:0]];
            end
            else
            begin
                case (code)
                    `SSO_CODE_OLW: sel_decode = overload_warning_out;
                    `SSO_CODE_FAULT: sel_decode = fault;
                    `SSO_CODE_WARN: sel_decode = warn;
                    `SSO_CODE_RLIM: sel_decode = rlim;
                    `SSO_CODE_FLIM: sel_decode = flim;
                    `SSO_CODE_SPOK: sel_decode = spok;
                    default: sel_decode = 1'b0;
                endcase
            end
        end
    endfunction

    // Saturating cut of the forty-bit threshold to the thirty-two-bit compare width.
    function [31:0] sat32;
        input [39:0] value;
        begin
            if (value[39:32] != 8'h00)
            begin
                sat32 = 32'hFFFF_FFFF;
            end
            else
            begin
                sat32 = value[31:0];
            end
        end
    endfunction

    // The APB slave answers with zero wait states in the access phase.
    assign wr_en = PSEL & PENABLE & PWRITE;
    assign rd_en = PSEL & PENABLE & ~PWRITE;
    assign clr_req = wr_en && PADDR == `SSO_OFF_CTRL && PWDATA[`SSO_CTRL_CLR];

    // The warning threshold is registered, so a parameter write shows one cycle later.
    // The percent divide keeps all forty bits; only the saturating cut narrows it.
    assign prod = perm_r * pct_r;
    assign thr_full = prod / {8'h00, `SSO_PCT_DIV};

    // Listed faults raise the warning, anything else raises the fault.
    assign warn_src = REV_LIMIT_ERR | FWD_LIMIT_ERR | ESTOP | COMM_ERR | UNDERVOLT;
    assign fault_src = alarm_r | OTHER_FAULT;
    assign olw_src = OVERLOAD && ol_time_r > warn_thr_r;
    assign spok_src = (CTRL_MODE == `SSO_MODE_SPEED || CTRL_MODE == `SSO_MODE_SPEED_ZERO)
        && SPEED_ERR <= win_r;

    // Event sources, one per event register bit.
    assign src[`SSO_EV_OLW] = olw_src;
    assign src[`SSO_EV_ALARM] = alarm_r;
    assign src[`SSO_EV_WARN] = warn_src;
    assign src[`SSO_EV_RLIM] = REV_SOFT_LIMIT;
    assign src[`SSO_EV_FLIM] = FWD_SOFT_LIMIT;
    assign src[`SSO_EV_SPOK] = spok_src;

    // Continuous overload time restarts whenever the overload condition drops.
    always @*
    begin
        ol_time_nxt = ol_time_r;
        if (!OVERLOAD)
        begin
            ol_time_nxt = 32'h0000_0000;
        end
        else if (OL_TICK && ol_time_r != 32'hFFFF_FFFF)
        begin
            ol_time_nxt = ol_time_r + 32'h0000_0001;
        end
    end

    // Output selection: every pin runs the same decode on its own code.
    always @*
    begin
        for (i = 0; i < `SSO_NUM_OUT; i = i + 1)
        begin
            do_nxt[i] = sel_decode(sel_r[i], olw_src, fault_src, warn_src, REV_SOFT_LIMIT,
                FWD_SOFT_LIMIT, spok_src, sword_r);
        end
    end

    // Sticky events; a new event wins over a read clear. The clear takes only
    // the bits that the read reported, since the read data were latched in the
    // setup cycle and an event of that cycle would otherwise be lost unseen.
    always @*
    begin
        ev_nxt = ev_r;
        if (rd_en && PADDR == `SSO_OFF_IRQ)
        begin
            ev_nxt = ev_r & ~PRDATA[5:0];
        end
        ev_nxt = ev_nxt | (src & ~prev_r);
    end

    // Read data multiplexer; unmapped addresses read zero.
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        case (PADDR)
            `SSO_OFF_SEL0: rdata_nxt = {sel_r[3], sel_r[2], sel_r[1], sel_r[0]};
            `SSO_OFF_SEL1: rdata_nxt = {16'h0000, sel_r[5], sel_r[4]};
            `SSO_OFF_PERM: rdata_nxt = perm_r;
            `SSO_OFF_PCT: rdata_nxt = {24'h00_0000, pct_r};
            `SSO_OFF_WIN: rdata_nxt = {16'h0000, win_r};
            `SSO_OFF_SWORD: rdata_nxt = {16'h0000, sword_r};
            `SSO_OFF_STAT: rdata_nxt = {25'h000_0000, alarm_r, DO_OUT};
            `SSO_OFF_IRQ: rdata_nxt = {26'h000_0000, ev_r};
            `SSO_OFF_MASK: rdata_nxt = {26'h000_0000, mask_r};
            `SSO_OFF_OLTIME: rdata_nxt = ol_time_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Continuous overload time in ticks; it only moves while the motor is overloaded.
    // It stops at the top value instead of wrapping, so a very long overload stays seen.
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            ol_time_r <= 32'h0000_0000;
        end
        else
        begin
            ol_time_r <= ol_time_nxt;
        end
    end

    // Warning threshold register; the saturating cut keeps a huge product from
    // wrapping round to a small threshold and warning far too early.
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            warn_thr_r <= 32'h0000_0000;
        end
        else
        begin
            warn_thr_r <= sat32(thr_full);
        end
    end

    // Overload alarm latch; it holds until software clears it.
    // An overload past the permitted time wins over the clear, so the alarm cannot be dismissed while that lasts.
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            alarm_r <= 1'b0;
        end
        else if (OVERLOAD && ol_time_r > perm_r)
        begin
            alarm_r <= 1'b1;
        end
        else if (clr_req)
        begin
            alarm_r <= 1'b0;
        end
    end

    // Selection code registers; a write lands at the access edge of the transfer.
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            for (j = 0; j < `SSO_NUM_OUT; j = j + 1)
            begin
                sel_r[j] <= `SSO_CODE_OFF;
            end
        end
        else if (wr_en && PADDR == `SSO_OFF_SEL0)
        begin
            sel_r[0] <= PWDATA[7:0];
            sel_r[1] <= PWDATA[15:8];
            sel_r[2] <= PWDATA[23:16];
            sel_r[3] <= PWDATA[31:24];
        end
        else if (wr_en && PADDR == `SSO_OFF_SEL1)
        begin
            sel_r[4] <= PWDATA[7:0];
            sel_r[5] <= PWDATA[15:8];
        end
    end

    // Overload, window, software word and mask registers; other addresses are ignored.
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            perm_r <= `SSO_RST_PERM;
            pct_r <= `SSO_RST_PCT;
            win_r <= `SSO_RST_WIN;
            sword_r <= 16'h0000;
            mask_r <= 6'h00;
        end
        else if (wr_en)
        begin
            case (PADDR)
                `SSO_OFF_PERM: perm_r <= PWDATA;
                `SSO_OFF_PCT: pct_r <= PWDATA[7:0];
                `SSO_OFF_WIN: win_r <= PWDATA[15:0];
                `SSO_OFF_SWORD: sword_r <= PWDATA[15:0];
                `SSO_OFF_MASK: mask_r <= PWDATA[5:0];
                default: mask_r <= mask_r;
            endcase
        end
    end

    // Pin outputs come straight from flip-flops, so a pin never glitches while a
    // code or source settles; the price is one clock of delay.
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            DO_OUT <= 6'h00;
            OVERLOAD_ALARM_DISPLAY <= 1'b0;
        end
        else
        begin
            DO_OUT <= do_nxt;
            OVERLOAD_ALARM_DISPLAY <= alarm_r;
        end
    end

    // Sticky events and the level interrupt, which follows the next event value.
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            ev_r <= 6'h00;
            prev_r <= 6'h00;
            IRQ <= 1'b0;
        end
        else
        begin
            prev_r <= src;
            ev_r <= ev_nxt;
            IRQ <= |(ev_nxt & mask_r);
        end
    end

    // Bus answer: ready in the first access cycle and never an error.
    // Read data follow the address every cycle, so they stand at the access edge.
    always @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= 1'b0;
            PRDATA <= rdata_nxt;
        end
    end

endmodule // sso_top

/* design/sso_consts.vh */
// Purpose: Constants for the servo status output select block.
// Assumes: Included by the block's design file only.
// Notes: Register offsets are byte addresses on the APB bus.
`ifndef SSO_CONSTS_VH
`define SSO_CONSTS_VH
// Output selection codes.
`define SSO_CODE_OFF 8'h00
`define SSO_CODE_FAULT 8'h07
`define SSO_CODE_OLW 8'h10
`define SSO_CODE_WARN 8'h11
`define SSO_CODE_RLIM 8'h13
`define SSO_CODE_FLIM 8'h14
`define SSO_CODE_SPOK 8'h19
`define SSO_CODE_SDO0 8'h30
`define SSO_CODE_SDOF 8'h3F
// Register byte offsets.
`define SSO_OFF_SEL0 12'h000
`define SSO_OFF_SEL1 12'h004
`define SSO_OFF_PERM 12'h008
`define SSO_OFF_PCT 12'h00C
`define SSO_OFF_WIN 12'h010
`define SSO_OFF_SWORD 12'h014
`define SSO_OFF_CTRL 12'h018
`define SSO_OFF_STAT 12'h01C
`define SSO_OFF_IRQ 12'h020
`define SSO_OFF_MASK 12'h024
`define SSO_OFF_OLTIME 12'h028
// Reset values.
`define SSO_RST_PERM 32'h0000_0000
`define SSO_RST_PCT 8'h00
`define SSO_RST_WIN 16'h0000
// Field positions and counts.
`define SSO_CTRL_CLR 0
`define SSO_NUM_OUT 6
`define SSO_NUM_SRC 8
// Sticky event bits.
`define SSO_EV_OLW 0
`define SSO_EV_ALARM 1
`define SSO_EV_WARN 2
`define SSO_EV_RLIM 3
`define SSO_EV_FLIM 4
`define SSO_EV_SPOK 5
`define SSO_EV_W 6
// Control modes on the CTRL_MODE input, and the percent divisor of the warning threshold.
`define SSO_MODE_SPEED 3'h1
`define SSO_MODE_SPEED_ZERO 3'h2
`define SSO_PCT_DIV 32'h0000_0064
`endif

/* testbench/sso_asserts.sv */
// Purpose: Port-level checks on the status output select block.
// Assumes: Selection codes are tracked from APB writes to the two selection words.
// Notes: A pin shows its source one clock edge after the source is sampled.
`timescale 1ns/1ps
module sso_asserts (
    input wire SYS_CLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire OVERLOAD,
    input wire REV_LIMIT_ERR,
    input wire FWD_LIMIT_ERR,
    input wire ESTOP,
    input wire COMM_ERR,
    input wire UNDERVOLT,
    input wire REV_SOFT_LIMIT,
    input wire FWD_SOFT_LIMIT,
    input wire [5:0] DO_OUT,
    input wire OVERLOAD_ALARM_DISPLAY
);
    reg [31:0] sel0_r;
    reg [31:0] sel1_r;
    // Shadows of the selection words, so each check knows which source drives a pin.
    always @(posedge SYS_CLK or posedge RST)
        if (RST)
        begin
            sel0_r <= 32'h0000_0000;
            sel1_r <= 32'h0000_0000;
        end
        else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000)
            sel0_r <= PWDATA;
        else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h004)
            sel1_r <= PWDATA;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_no_wr; !PSEL && !$past(PSEL) && !$past(PSEL, 2); endsequence
    sequence s_alarm_on; OVERLOAD_ALARM_DISPLAY; endsequence
    property p_ready; s_setup |=> PENABLE && PREADY; endproperty
    a_ready: assert property (p_ready) else $error("No ready in access phase.");
    property p_noerr; PREADY |-> !PSLVERR; endproperty
    a_noerr: assert property (p_noerr) else $error("Unexpected slave error.");
    property p_rlim; (sel0_r[7:0] == 8'h13)[*4] |-> DO_OUT[0] == $past(REV_SOFT_LIMIT); endproperty
    a_rlim: assert property (p_rlim) else $error("Reverse limit output wrong.");
    property p_flim; (sel0_r[15:8] == 8'h14)[*4] |-> DO_OUT[1] == $past(FWD_SOFT_LIMIT); endproperty
    a_flim: assert property (p_flim) else $error("Forward limit output wrong.");
    property p_warn; (sel0_r[23:16] == 8'h11)[*4] |->
        DO_OUT[2] == $past(REV_LIMIT_ERR || FWD_LIMIT_ERR || ESTOP || COMM_ERR || UNDERVOLT); endproperty
    a_warn: assert property (p_warn) else $error("Warning output wrong.");
    property p_off; (sel1_r[7:0] == 8'h00)[*4] |-> !DO_OUT[4]; endproperty
    a_off: assert property (p_off) else $error("Disabled output active.");
    property p_latch; (s_alarm_on and s_no_wr) |=> OVERLOAD_ALARM_DISPLAY; endproperty
    a_latch: assert property (p_latch) else $error("Alarm dropped without clear.");
    property p_alarm; $rose(OVERLOAD_ALARM_DISPLAY) |-> $past(OVERLOAD) || $past(OVERLOAD, 2); endproperty
    a_alarm: assert property (p_alarm) else $error("Alarm without overload.");
endmodule // sso_asserts
bind sso_top sso_asserts u_chk (.*);

/* testbench/sso_plc.sv */
// Purpose: Machine controller that samples the drive's status outputs.
// Assumes: Outputs are synchronous levels.
// Notes: One cycle of sampling delay, as a real input stage would add.
`timescale 1ns/1ps
module sso_plc (
    input wire clk,
    input wire [5:0] d,
    output reg [5:0] q
);
    // Registered sampling keeps the reader from catching a changing pin.
    always @(posedge clk)
        q <= d;
endmodule // sso_plc

/* testbench/test_servo_status_output_select.sv */
// Purpose: Directed tests of the status output select block.
// Assumes: APB answers in the first access cycle; outputs lag by two cycles.
// Notes: Outputs are read through the controller model.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("Error %0t: %h not %h", $time, a, e); end end
module test_servo_status_output_select;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ovl = 0, tick = 0, rsl = 0, fsl = 0, oth = 0;
    logic [11:0] pa = 0;
    logic [31:0] pd = 0, prd, r;
    logic [4:0] wf = 0;
    logic [2:0] mode = 0;
    logic [15:0] serr = 0;
    logic prdy, slv, disp, irq;
    logic [5:0] dout, q;
    int checked = 0, error_cnt = 0, i;
    sso_top i_dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pd),
        .PRDATA(prd), .PREADY(prdy), .PSLVERR(slv), .OVERLOAD(ovl), .OL_TICK(tick), .REV_LIMIT_ERR(wf[0]),
        .FWD_LIMIT_ERR(wf[1]), .ESTOP(wf[2]), .COMM_ERR(wf[3]), .UNDERVOLT(wf[4]), .OTHER_FAULT(oth),
        .REV_SOFT_LIMIT(rsl), .FWD_SOFT_LIMIT(fsl), .CTRL_MODE(mode), .SPEED_ERR(serr), .DO_OUT(dout),
        .OVERLOAD_ALARM_DISPLAY(disp), .IRQ(irq));
    sso_plc i_plc (.clk(clk), .d(dout), .q(q));
    // Free-running 200 MHz clock.
    initial forever #2.5 clk = ~clk;
    // One APB transfer; the request is held until ready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Overload time units arrive as single-cycle pulses.
    task automatic tk(input int n);
        repeat (n) begin @(posedge clk); tick <= 1; @(posedge clk); tick <= 0; end
    endtask
    task conclude;
        $display("Checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // A hang counts as a mismatch; the tests need far less time than this.
    initial
    begin
        #40000;
        error_cnt++;
        conclude;
    end
    // Main sequence: selection codes, fault grouping, overload thresholds, events.
    initial
    begin
        wt(5);
        rst <= 0;
        apb(1'b0, 12'h0FC, 32'h0, r); `CHK(r, 32'h0)
        wr(12'h000, 32'h3011_1413); wr(12'h004, 32'h0000_1019); wr(12'h008, 32'd10);
        wr(12'h00C, 32'd50); wr(12'h010, 32'h10); wr(12'h014, 32'h1); wr(12'h024, 32'h2);
        rsl <= 1; mode <= 3'h1; serr <= 16'h0010; wt(4); `CHK(q, 6'b011001)
        rsl <= 0; fsl <= 1; serr <= 16'h0011; wt(4); `CHK(q, 6'b001010)
        serr <= 16'h0; mode <= 3'h0; wt(4); `CHK(q[4], 1'b0)
        mode <= 3'h2; wt(4); `CHK(q[4], 1'b1)
        for (i = 0; i < 5; i++) begin wf <= 5'h01 << i; wt(4); `CHK(q[2], 1'b1) end
        wf <= 0; wt(4); `CHK(q[2], 1'b0)
        wr(12'h014, 32'h8000); wr(12'h000, 32'h3F11_1413); wt(4); `CHK(q[3], 1'b1)
        wr(12'h004, 32'h0000_1000); wr(12'h014, 32'h0); wt(4); `CHK(q[4:3], 2'b00)
        $display("Selection tests done");
        ovl <= 1; tk(5); wt(4); `CHK(q[5], 1'b0)
        tk(1); wt(4); `CHK(q[5], 1'b1)
        tk(4); wt(4); `CHK(disp, 1'b0)
        tk(1); wt(4); `CHK(disp, 1'b1)
        `CHK(irq, 1'b1)
        wr(12'h000, 32'h3011_1407); wt(4); `CHK(q[0], 1'b1)
        ovl <= 0; wt(4); `CHK({q[5], disp}, 2'b01)
        apb(1'b0, 12'h020, 32'h0, r); `CHK(r, 32'h3F)
        wt(2); `CHK(irq, 1'b0)
        wr(12'h018, 32'h1); wt(4); `CHK({q[0], disp}, 2'b00)
        oth <= 1; wt(4); `CHK({q[2], q[0]}, 2'b01)
        oth <= 0; wf <= 5'h04; wt(4); `CHK({q[2], q[0]}, 2'b10)
        $display("Overload and fault tests done");
        conclude;
    end
endmodule // test_servo_status_output_select
